// ===== rtl/pcci_pkg.sv
// package: register map, field layout and carrier types for the socket interrupt event block
package pcci_pkg;
  // register offsets on the register port
  localparam logic [11:0] ADDR_LEG_FLAGS = 12'h004;
  localparam logic [11:0] ADDR_LEG_MASK = 12'h005;
  localparam logic [11:0] ADDR_GLB_CTL = 12'h01e;
  localparam logic [11:0] ADDR_FUNC = 12'h091;
  localparam logic [11:0] ADDR_SOCK_EVT = 12'h100;
  localparam logic [11:0] ADDR_SOCK_MASK = 12'h104;
  localparam logic [11:0] ADDR_ROUTE = 12'h108;
  // reset values
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [7:0] RST_LEG_MASK = 8'h00;
  localparam logic [7:0] RST_GLB_CTL = 8'h00;
  localparam logic [3:0] RST_SOCK_MASK = 4'h0;
  localparam logic [8:0] RST_ROUTE = 9'h1ff;
  // field positions
  localparam int FLAG_BIT_ZERO = 0;
  localparam int FLAG_BIT_ONE = 1;
  localparam int FLAG_BIT_TWO = 2;
  localparam int FLAG_BIT_PWR = 3;
  localparam int GLB_FLAG_CLEAR_SEL = 2;
  localparam int FUNC_FLAG_BIT = 0;
  // pin numbering
  localparam int NUM_PINS = 7;
  localparam logic [2:0] PIN_NONE = 3'h7;
  localparam logic [2:0] PIN_SERIAL = 3'h6;
  // card kinds seen at the socket
  typedef enum logic [1:0] {
    PCCI_KIND_NONE = 2'h0,
    PCCI_KIND_MEM16 = 2'h1,
    PCCI_KIND_IO16 = 2'h2,
    PCCI_KIND_WIDE = 2'h3
  } pcci_kind_t;
  // socket pins, active high after the pad buffers
  typedef struct packed {
    logic battery_detect_one;
    logic battery_detect_two;
    logic card_ready;
    logic card_status_change_line;
    logic io_card_irq_request;
    logic wide_card_status_change;
    logic wide_card_interrupt;
    logic card_detect_one;
    logic card_detect_two;
  } pcci_sock_t;
  // routing register layout, high bits first
  typedef struct packed {
    logic serial_en;
    logic func_isa;
    logic [2:0] func_pin;
    logic csc_isa;
    logic [2:0] csc_pin;
  } pcci_route_t;
endpackage

// ===== rtl/pcci_edge.sv
// module: registered edge and rise detector over a vector of socket pins
`timescale 1ns/1ns
module pcci_edge
  import pcci_pkg::*;
#(
  parameter int W = 9
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // sampled pins
  input wire logic [W-1:0] pins,
  // one-cycle results
  output logic [W-1:0] any_edge,
  output logic [W-1:0] rise
);
  logic [W-1:0] prev_r; // last sample
  logic [W-1:0] prev_nxt;
  logic primed_r; // blocks a false edge on the first sample after reset
  logic primed_nxt;

  // next sample state
  always_comb begin
    prev_nxt = pins;
    primed_nxt = 1'b1;
  end

  // register samples
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_r <= '0;
      primed_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      primed_r <= primed_nxt;
    end
  end

  // edges only once a real previous sample exists
  assign any_edge = primed_r ? (pins ^ prev_r) : '0;
  assign rise = primed_r ? (pins & ~prev_r) : '0;
endmodule

// ===== rtl/pcci_route.sv
// module: steers status-change and functional requests onto the multifunction pins
`timescale 1ns/1ns
module pcci_route
  import pcci_pkg::*;
(
  // requests
  input wire logic csc_req,
  input wire logic func_req,
  // routing setup
  input wire pcci_route_t route,
  // pin drive
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe
);
  logic [2:0] csc_sel; // effective pin per class
  logic [2:0] func_sel;

  // pick pins and drive style per class
  always_comb begin
    pin_out = {NUM_PINS{1'b1}};
    pin_oe = '0;
    // isa-style requests leave on the serialized line when it is enabled
    csc_sel = (route.serial_en && route.csc_isa) ? PIN_SERIAL : route.csc_pin;
    func_sel = (route.serial_en && route.func_isa) ? PIN_SERIAL : route.func_pin;
    for (int i = 0; i < NUM_PINS; i++) begin
      // open-drain bus interrupt: pull low only while requested
      if (csc_sel == i[2:0] && !route.csc_isa && csc_req) begin
        pin_out[i] = 1'b0;
        pin_oe[i] = 1'b1;
      end
      if (func_sel == i[2:0] && !route.func_isa && func_req) begin
        pin_out[i] = 1'b0;
        pin_oe[i] = 1'b1;
      end
    end
    // isa-style level lines: driven all the time, high while requested
    for (int i = 0; i < NUM_PINS; i++) begin
      if ((csc_sel == i[2:0] && route.csc_isa) || (func_sel == i[2:0] && route.func_isa)) begin
        pin_oe[i] = 1'b1;
        pin_out[i] = (csc_sel == i[2:0] && route.csc_isa && csc_req) ||
                     (func_sel == i[2:0] && route.func_isa && func_req);
      end
    end
  end
endmodule

// ===== rtl/pcci_events.sv
// module: per-socket interrupt event flags, masks, clearing and pin routing
//
// Behaviour
// - memory card battery-line transitions set flags 1,0
// - memory card ready transitions set flag 2
// - io card status-change assertion sets flag 0
// - io card irq passes unmasked, flags byte
// - wide card status-change sets socket event 0
// - wide card interrupt passes unmasked, flags byte
// - card-detect transitions set socket events 2,1
// - power-up complete sets bit 3 flag
// - no functional interrupts for memory cards
// - all sources flagged; change events maskable
// - software routes both classes to separate outputs
// - legacy flags clear on read or write-one
// - socket event flags clear on write-one
// - all signalling only on seven multifunction pins
// - parallel bus, parallel isa, serialized line
`timescale 1ns/1ns
module pcci_events
  import pcci_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // socket side
  input wire pcci_sock_t sock,
  input wire pcci_kind_t card_kind,
  input wire logic power_up_done,
  // multifunction pins
  output logic [NUM_PINS-1:0] multifunction_pins_out,
  output logic [NUM_PINS-1:0] multifunction_pins_oe
);
  // every sticky flag and mask is a plain register next to its next value; the
  // legacy byte keeps only bits 3:0 as flags because no other source exists here
  // the legacy mask keeps its full byte so software reads back what it wrote
  // register state
  logic [3:0] leg_flags_r, leg_flags_nxt; // legacy status-change flags
  logic [7:0] leg_mask_r, leg_mask_nxt; // legacy mask byte
  logic [7:0] glb_ctl_r, glb_ctl_nxt; // legacy global control byte
  logic func_flag_r, func_flag_nxt; // functional request flag
  logic [3:0] sock_evt_r, sock_evt_nxt; // wide-card socket events
  logic [3:0] sock_mask_r, sock_mask_nxt; // wide-card socket mask
  pcci_route_t route_r, route_nxt; // routing setup
  // read answer and pin drive
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [NUM_PINS-1:0] pin_out_r, pin_oe_r;
  logic [NUM_PINS-1:0] pin_out_w, pin_oe_w;

  // event detection
  logic [8:0] edge_any_w, edge_rise_w;
  pcci_sock_t chg, ris; // transitions and assertions per pin
  logic is_mem, is_io, is_wide;
  logic [3:0] leg_set, leg_clr, sock_set, sock_clr;
  logic func_set, func_clr, func_lvl;
  logic flag_clear_select; // 1: write-one clears, 0: read clears
  logic csc_req, func_req;

  // one detector covers all nine socket pins; its first sample after reset is
  // ignored so a card already seated at power-on does not look like an insertion
  // the pins are taken as synchronous, so no extra stage sits in front of it
  pcci_edge #(
    .W(9)
  ) u_edge (
    .clock(clock),
    .rst(rst),
    .pins(sock),
    .any_edge(edge_any_w),
    .rise(edge_rise_w)
  );

  // view the detector outputs with the socket field names again
  assign chg = pcci_sock_t'(edge_any_w);
  assign ris = pcci_sock_t'(edge_rise_w);
  // card kind decides what each shared pin means
  assign is_mem = (card_kind == PCCI_KIND_MEM16);
  assign is_io = (card_kind == PCCI_KIND_IO16);
  assign is_wide = (card_kind == PCCI_KIND_WIDE);
  assign flag_clear_select = glb_ctl_r[GLB_FLAG_CLEAR_SEL];

  // the socket pins are shared between card kinds: the battery line of a memory
  // card is the status-change line of an io card and of a wide card, and the
  // ready line doubles as the interrupt request; gating on the card kind keeps
  // one pin from feeding two flags at once
  // battery and ready count any transition, status change and irq only assertion
  // event sources; apart from the card-detect pins, each pin means something different per card kind
  always_comb begin
    leg_set = '0;
    sock_set = '0;
    leg_set[FLAG_BIT_ZERO] = (is_mem && chg.battery_detect_one) ||
                             (is_io && ris.card_status_change_line);
    leg_set[FLAG_BIT_ONE] = is_mem && chg.battery_detect_two;
    leg_set[FLAG_BIT_TWO] = is_mem && chg.card_ready;
    leg_set[FLAG_BIT_PWR] = power_up_done && (is_mem || is_io);
    sock_set[FLAG_BIT_ZERO] = is_wide && ris.wide_card_status_change;
    // insertion and removal do not depend on the card kind
    sock_set[FLAG_BIT_ONE] = chg.card_detect_one;
    sock_set[FLAG_BIT_TWO] = chg.card_detect_two;
    sock_set[FLAG_BIT_PWR] = power_up_done && is_wide;
    // memory cards have no functional request at all
    func_set = (is_io && ris.io_card_irq_request) || (is_wide && ris.wide_card_interrupt);
    func_lvl = (is_io && sock.io_card_irq_request) || (is_wide && sock.wide_card_interrupt);
  end

  // flag clearing follows the global clear-select bit: reads clear in the
  // default mode, writes of one clear in the other; the two never both act, so
  // software that mixes the styles only loses the method it did not select
  // socket events and the functional flag clear on a written one only
  // clear terms from the register port
  always_comb begin
    leg_clr = '0;
    sock_clr = '0;
    func_clr = 1'b0;
    if (reg_rd && reg_addr == ADDR_LEG_FLAGS && !flag_clear_select) begin
      leg_clr = 4'hf;
    end
    if (reg_wr && reg_addr == ADDR_LEG_FLAGS && flag_clear_select) begin
      leg_clr = reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == ADDR_SOCK_EVT) begin
      sock_clr = reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == ADDR_FUNC) begin
      func_clr = reg_wdata[FUNC_FLAG_BIT];
    end
  end

  // an event that lands in the same cycle as its clear must not be lost, so the
  // set term is ored in after the clear mask is applied
  // writes to the control registers take effect on the next edge
  // unmapped writes fall through the default branch and change nothing
  // next register values; a set in the clearing cycle survives
  always_comb begin
    leg_flags_nxt = (leg_flags_r & ~leg_clr) | leg_set;
    sock_evt_nxt = (sock_evt_r & ~sock_clr) | sock_set;
    func_flag_nxt = (func_flag_r & ~func_clr) | func_set;
    leg_mask_nxt = leg_mask_r;
    glb_ctl_nxt = glb_ctl_r;
    sock_mask_nxt = sock_mask_r;
    route_nxt = route_r;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_LEG_MASK: leg_mask_nxt = reg_wdata[7:0];
        ADDR_GLB_CTL: glb_ctl_nxt = reg_wdata[7:0];
        ADDR_SOCK_MASK: sock_mask_nxt = reg_wdata[3:0];
        ADDR_ROUTE: route_nxt = pcci_route_t'(reg_wdata[8:0]);
        default: ;
      endcase
    end
  end

  // read data is registered so the answer always follows the strobe by exactly
  // one cycle; between reads it holds, which keeps the bus quiet
  // upper bits of narrow registers read as zero
  // read mux; the value returned is the one before any clear-on-read
  always_comb begin
    rvalid_nxt = reg_rd;
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_LEG_FLAGS: rdata_nxt = {28'h0, leg_flags_r};
        ADDR_LEG_MASK: rdata_nxt = {24'h0, leg_mask_r};
        ADDR_GLB_CTL: rdata_nxt = {24'h0, glb_ctl_r};
        ADDR_FUNC: rdata_nxt = {31'h0, func_flag_r};
        ADDR_SOCK_EVT: rdata_nxt = {28'h0, sock_evt_r};
        ADDR_SOCK_MASK: rdata_nxt = {28'h0, sock_mask_r};
        ADDR_ROUTE: rdata_nxt = {23'h0, route_r};
        default: rdata_nxt = 32'h0; // unmapped reads as zero
      endcase
    end
  end

  // a status-change request stands while any flag that its mask enables is
  // still set, so the output drops only after software has cleared or masked them all
  // the functional request also follows the live irq level, so a card that keeps
  // its line asserted after the flag was cleared is still seen
  // request classes; functional needs no mask, the card only asserts it once powered
  assign csc_req = |(leg_flags_r & leg_mask_r[3:0]) || |(sock_evt_r & sock_mask_r);
  assign func_req = func_flag_r || func_lvl;

  // the router works on the registered flags, the live irq level and the registered routing, and its outputs are
  // registered once more so every pin leaves straight from a flip-flop; the cost
  // is one extra cycle of latency from flag to pin
  // routing both classes to one pin is allowed; with the same drive style it merges them, with mixed styles the isa-style class alone sets that pin
  pcci_route u_route (
    .csc_req(csc_req),
    .func_req(func_req),
    .route(route_r),
    .pin_out(pin_out_w),
    .pin_oe(pin_oe_w)
  );

  // single clocked process for all state; reset puts the pins into release,
  // except that the routing reset sends both classes to the serialized line,
  // which the router then drives at its idle level
  // only constants are loaded in the reset branch
  // register everything
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      leg_flags_r <= RST_FLAGS;
      leg_mask_r <= RST_LEG_MASK;
      glb_ctl_r <= RST_GLB_CTL; // clear-on-read after reset
      func_flag_r <= 1'b0;
      sock_evt_r <= RST_FLAGS;
      sock_mask_r <= RST_SOCK_MASK;
      route_r <= pcci_route_t'(RST_ROUTE);
      rdata_r <= 32'h0;
      rvalid_r <= 1'b0;
      pin_out_r <= {NUM_PINS{1'b1}};
      pin_oe_r <= '0;
    end else begin
      leg_flags_r <= leg_flags_nxt;
      leg_mask_r <= leg_mask_nxt;
      glb_ctl_r <= glb_ctl_nxt;
      func_flag_r <= func_flag_nxt;
      sock_evt_r <= sock_evt_nxt;
      sock_mask_r <= sock_mask_nxt;
      route_r <= route_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      pin_out_r <= pin_out_w;
      pin_oe_r <= pin_oe_w;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign multifunction_pins_out = pin_out_r;
  assign multifunction_pins_oe = pin_oe_r;

  // checks; all of them run on the one clock and are quiet during reset
  // each flag check looks one edge after the source is seen, matching the
  // registered flag path above
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // flag setting, one check per source
  battery_one_flag_a: assert property (is_mem && chg.battery_detect_one |=> leg_flags_r[FLAG_BIT_ZERO])
    else $error("battery transition did not set flag 0");
  battery_flag_a: assert property (is_mem && chg.battery_detect_two |=> leg_flags_r[FLAG_BIT_ONE])
    else $error("battery transition did not set flag 1");
  ready_flag_a: assert property (is_mem && chg.card_ready |=> leg_flags_r[FLAG_BIT_TWO])
    else $error("ready transition did not set flag 2");
  io_change_flag_a: assert property (is_io && ris.card_status_change_line |=> leg_flags_r[FLAG_BIT_ZERO])
    else $error("io status change did not set flag 0");
  wide_change_flag_a: assert property (is_wide && ris.wide_card_status_change |=> sock_evt_r[FLAG_BIT_ZERO])
    else $error("wide status change did not set event 0");
  func_flag_a: assert property (func_set |=> func_flag_r ##1 (func_flag_r || $past(func_clr)))
    else $error("functional request not flagged");
  mem_no_func_a: assert property (is_mem && !func_flag_r |=> !func_flag_r)
    else $error("memory card raised a functional flag");
  detect_flag_a: assert property (chg.card_detect_one |=> sock_evt_r[FLAG_BIT_ONE])
    else $error("card detect transition not flagged");
  detect_two_flag_a: assert property (chg.card_detect_two |=> sock_evt_r[FLAG_BIT_TWO])
    else $error("second card detect transition not flagged");
  power_flag_a: assert property (power_up_done && is_wide |=> sock_evt_r[FLAG_BIT_PWR])
    else $error("power complete not flagged");
  legacy_power_a: assert property (power_up_done && (is_mem || is_io) |=> leg_flags_r[FLAG_BIT_PWR])
    else $error("power complete not flagged in legacy flags");

  // clearing by read and by written one
  read_clear_a: assert property (reg_rd && reg_addr == ADDR_LEG_FLAGS && !flag_clear_select && leg_set == 4'h0
    |=> leg_flags_r == 4'h0 && reg_rvalid)
    else $error("clear on read failed");
  write_keep_a: assert property (reg_wr && reg_addr == ADDR_SOCK_EVT && !reg_wdata[0] && sock_evt_r[0]
    |=> sock_evt_r[0])
    else $error("write of zero cleared an event");
  write_clear_a: assert property (reg_wr && reg_addr == ADDR_LEG_FLAGS && flag_clear_select
    && reg_wdata[FLAG_BIT_ZERO] && !leg_set[FLAG_BIT_ZERO] |=> !leg_flags_r[FLAG_BIT_ZERO])
    else $error("write of one did not clear legacy flag 0");
  sock_clear_a: assert property (reg_wr && reg_addr == ADDR_SOCK_EVT && reg_wdata[FLAG_BIT_ZERO]
    && !sock_set[FLAG_BIT_ZERO] |=> !sock_evt_r[FLAG_BIT_ZERO])
    else $error("write of one did not clear socket event 0");

  // pin drive and release
  csc_pin_hold_a: assert property (csc_req && !route_r.csc_isa && !route_r.serial_en && route_r.csc_pin != PIN_NONE
    |=> multifunction_pins_oe[$past(route_r.csc_pin)] && !multifunction_pins_out[$past(route_r.csc_pin)])
    else $error("status change output not driven");
  idle_release_a: assert property (!csc_req && !func_req && !route_r.csc_isa && !route_r.func_isa
    |=> multifunction_pins_oe == '0 && multifunction_pins_out == '1)
    else $error("pins not released while idle");
  func_pin_a: assert property (func_req && !route_r.func_isa && !route_r.csc_isa
    && route_r.func_pin != PIN_NONE
    |=> multifunction_pins_oe[$past(route_r.func_pin)] && !multifunction_pins_out[$past(route_r.func_pin)])
    else $error("functional output not driven");
  serial_level_a: assert property (route_r.serial_en && route_r.func_isa && !route_r.csc_isa
    |=> multifunction_pins_oe[PIN_SERIAL] && multifunction_pins_out[PIN_SERIAL] == $past(func_req))
    else $error("serialized line does not follow the functional request");

  // cover the main scenarios
  insert_c: cover property (chg.card_detect_one ##1 csc_req);
  mask_c: cover property (|(sock_evt_r & sock_mask_r) ##2 multifunction_pins_out[PIN_SERIAL]);
  serial_c: cover property (route_r.serial_en && route_r.func_isa && func_req ##1 multifunction_pins_out[PIN_SERIAL]);
  func_c: cover property (is_io && func_set ##2 func_req);
  clear_c: cover property (leg_flags_r != 4'h0 ##1 reg_rd && reg_addr == ADDR_LEG_FLAGS ##1 leg_flags_r == 4'h0);
endmodule

// ===== verif/pcci_sock_model.sv
// socket-side model: card kind, socket pins and power-up pulse toward the event block
`timescale 1ns/1ns
module pcci_sock_model
  import pcci_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // socket state wanted by the bench
  input wire pcci_sock_t want_sock,
  input wire pcci_kind_t want_kind,
  input wire logic want_pwr,
  // toward the block
  output pcci_sock_t sock,
  output pcci_kind_t card_kind,
  output logic power_up_done
);
  logic pwr_seen_r; // power request already answered
  // pins move only at clock edges; a held power request gives a single done pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sock <= '0;
      card_kind <= PCCI_KIND_NONE;
      power_up_done <= 1'b0;
      pwr_seen_r <= 1'b0;
    end else begin
      sock <= want_sock;
      card_kind <= want_kind;
      power_up_done <= want_pwr & ~pwr_seen_r;
      pwr_seen_r <= want_pwr;
    end
  end
endmodule

// ===== verif/test_pcci_events.sv
// testbench: socket interrupt event flags, masks, clearing and pin routing
`timescale 1ns/1ns
module test_pcci_events;
  import pcci_pkg::*;
  logic clock;
  logic rst;
  logic [11:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  pcci_sock_t want_sock; // bench-side wish for the socket pins
  pcci_kind_t want_kind;
  logic want_pwr;
  pcci_sock_t sock;
  pcci_kind_t card_kind;
  logic power_up_done;
  logic [NUM_PINS-1:0] pins_out;
  logic [NUM_PINS-1:0] pins_oe;
  int n_mismatch = 0;
  int num_checks = 0;

  pcci_sock_model model (.clock(clock), .rst(rst), .want_sock(want_sock), .want_kind(want_kind),
    .want_pwr(want_pwr), .sock(sock), .card_kind(card_kind), .power_up_done(power_up_done));
  pcci_events dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sock(sock),
    .card_kind(card_kind), .power_up_done(power_up_done), .multifunction_pins_out(pins_out),
    .multifunction_pins_oe(pins_oe));

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read strobe; answer looked at while rvalid stands
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, exp);
  endtask
  // socket change reaches flags at N+1 and pins at N+2 after the model stage; the live irq level reaches pins at N+1
  task automatic settle();
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask
  // reset held 4 cycles with a chosen card kind and quiet pins
  task automatic do_reset(input pcci_kind_t k);
    @(posedge clock);
    rst <= 1'b1;
    want_sock <= '0;
    want_kind <= k;
    want_pwr <= 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  // reset values, unmapped address
  task automatic t_reset();
    do_reset(PCCI_KIND_NONE);
    rd(ADDR_LEG_FLAGS, 32'h0);
    rd(ADDR_LEG_MASK, 32'h0);
    rd(ADDR_GLB_CTL, 32'h0);
    rd(ADDR_SOCK_EVT, 32'h0);
    rd(ADDR_ROUTE, 32'h1ff);
    rd(ADDR_SOCK_MASK, 32'h0);
    rd(12'h0ff, 32'h0);
    chk({25'h0, pins_oe}, 32'h40);
    chk({25'h0, pins_out}, 32'h3f);
    $display("test reset done");
  endtask
  // memory card: battery and ready transitions, no functional irq
  task automatic t_mem();
    do_reset(PCCI_KIND_MEM16);
    want_sock.battery_detect_one <= 1'b1;
    settle();
    rd(ADDR_LEG_FLAGS, 32'h1);
    rd(ADDR_LEG_FLAGS, 32'h0);
    want_sock.battery_detect_one <= 1'b0;
    want_sock.battery_detect_two <= 1'b1;
    settle();
    rd(ADDR_LEG_FLAGS, 32'h3);
    want_sock.card_ready <= 1'b1;
    want_sock.io_card_irq_request <= 1'b1;
    settle();
    rd(ADDR_LEG_FLAGS, 32'h4);
    rd(ADDR_FUNC, 32'h0);
    want_pwr <= 1'b1;
    settle();
    rd(ADDR_LEG_FLAGS, 32'h8);
    $display("test memory card done");
  endtask
  // io card: status change and irq flag
  task automatic t_io();
    do_reset(PCCI_KIND_IO16);
    want_sock.card_status_change_line <= 1'b1;
    want_sock.io_card_irq_request <= 1'b1;
    settle();
    rd(ADDR_LEG_FLAGS, 32'h1);
    rd(ADDR_FUNC, 32'h1);
    want_sock.io_card_irq_request <= 1'b0;
    wr(ADDR_FUNC, 32'h1);
    settle();
    rd(ADDR_FUNC, 32'h0);
    $display("test io card done");
  endtask
  // wide card: the socket register set plus the functional flag register
  task automatic t_wide();
    do_reset(PCCI_KIND_WIDE);
    want_sock.wide_card_status_change <= 1'b1;
    settle();
    rd(ADDR_SOCK_EVT, 32'h1);
    chk({31'h0, pins_out[6]}, 32'h0);
    wr(ADDR_SOCK_MASK, 32'h1);
    settle();
    rd(ADDR_SOCK_MASK, 32'h1);
    chk({31'h0, pins_out[6]}, 32'h1);
    wr(ADDR_SOCK_EVT, 32'h0);
    rd(ADDR_SOCK_EVT, 32'h1);
    wr(ADDR_SOCK_EVT, 32'h1);
    rd(ADDR_SOCK_EVT, 32'h0);
    chk({31'h0, pins_out[6]}, 32'h0);
    want_sock.card_detect_one <= 1'b1;
    want_sock.card_detect_two <= 1'b1;
    want_sock.wide_card_interrupt <= 1'b1;
    settle();
    rd(ADDR_SOCK_EVT, 32'h6);
    rd(ADDR_FUNC, 32'h1);
    want_pwr <= 1'b1;
    settle();
    rd(ADDR_SOCK_EVT, 32'he);
    $display("test wide card done");
  endtask
  // masks, write-one clearing and routing onto the pins
  task automatic t_route();
    do_reset(PCCI_KIND_IO16);
    wr(ADDR_ROUTE, 32'h032);
    wr(ADDR_GLB_CTL, 32'h04);
    want_sock.card_status_change_line <= 1'b1;
    settle();
    chk({25'h0, pins_oe}, 32'h0);
    rd(ADDR_LEG_FLAGS, 32'h1);
    wr(ADDR_LEG_MASK, 32'h1);
    settle();
    chk({25'h0, pins_oe}, 32'h04);
    chk({31'h0, pins_out[2]}, 32'h0);
    rd(ADDR_LEG_FLAGS, 32'h1);
    chk({25'h0, pins_oe}, 32'h04);
    wr(ADDR_LEG_FLAGS, 32'h1);
    settle();
    chk({25'h0, pins_oe}, 32'h0);
    want_sock.io_card_irq_request <= 1'b1;
    settle();
    chk({25'h0, pins_oe}, 32'h08);
    wr(ADDR_ROUTE, 32'h1b2);
    settle();
    chk({31'h0, pins_oe[6]}, 32'h1);
    chk({31'h0, pins_out[6]}, 32'h1);
    want_sock.io_card_irq_request <= 1'b0;
    wr(ADDR_FUNC, 32'h1);
    settle();
    chk({31'h0, pins_out[6]}, 32'h0);
    $display("test routing done");
  endtask

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    reg_addr = 12'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0;
    want_sock = '0;
    want_kind = PCCI_KIND_NONE;
    want_pwr = 1'b0;
    t_reset();
    t_mem();
    t_io();
    t_wide();
    t_route();
    wrap_up();
  end
endmodule
